// ==== hdl/scg_system_clock_generator.v ====
// Summary of operation
// - Primary input comes from the external clock or the crystal as chosen.
// - Core rate is the primary input divided, multiplied, then divided.
// - A core rate above 80 MHz is flagged as unsupported and not enabled.
// - The core clock enable feeds the CPU, DMA, interrupt and cache.
// - Peripheral bus clock is the core clock divided by 1, 2, 4 or 8.
// - Peripheral bus clock enable drives timers and serial controllers.
// - The USB PLL is off after reset and runs only when switched on.
// - USB PLL input is primary divided to 4 MHz; divider must be two.
`timescale 1ns/100ps
`include "scg_defs.vh"
module scg_system_clock_generator #(
    parameter MAX_HZ = `SCG_CORE_MAX_HZ
) (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire ext_clk_in,
    input wire crystal_in,
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    output reg primary_clk_out,
    output reg core_clock_out,
    output reg peripheral_bus_clock_out,
    output reg usb_pll_clock_out,
    output reg cfg_error_out,
    output reg usb_cfg_error_out
);

////////////////////////////////////////////////////////////////////////
// Configuration, writable only until latched

reg primary_osc_mode_sel_q;
reg [1:0] periph_bus_divider_q;
reg usb_pll_on_q;
reg [3:0] sys_pll_in_divider_q;
reg [7:0] sys_pll_multiplier_q;
reg [7:0] sys_pll_out_divider_q;
reg [3:0] usb_pll_in_divider_q;
reg latched_q;
reg [31:0] lock_cnt_q;
reg locked_q;
reg [31:0] core_hz_q;

wire cfg_wr = wr_in && (addr_in == `SCG_REG_CFG) && !latched_q;
wire latch_wr = wr_in && (addr_in == `SCG_REG_LATCH) && wdata_in[0];

// Frozen after latch so derived clocks never see a mid-run change
always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        primary_osc_mode_sel_q <= `SCG_MODE_EXT_CLK;
        periph_bus_divider_q <= `SCG_PB_DIV8;
        usb_pll_on_q <= 1'b0;
        sys_pll_in_divider_q <= `SCG_RST_IDIV;
        sys_pll_multiplier_q <= `SCG_RST_MUL;
        sys_pll_out_divider_q <= `SCG_RST_ODIV;
        usb_pll_in_divider_q <= `SCG_RST_UDIV;
        latched_q <= 1'b0;
    end else begin
        if (cfg_wr) begin
            primary_osc_mode_sel_q <= wdata_in[`SCG_CFG_MODE];
            periph_bus_divider_q <=
                wdata_in[`SCG_CFG_PBDIV_HI:`SCG_CFG_PBDIV_LO];
            usb_pll_on_q <= wdata_in[`SCG_CFG_USBON];
            sys_pll_in_divider_q <=
                wdata_in[`SCG_CFG_IDIV_HI:`SCG_CFG_IDIV_LO];
            sys_pll_multiplier_q <=
                wdata_in[`SCG_CFG_MUL_HI:`SCG_CFG_MUL_LO];
            sys_pll_out_divider_q <=
                wdata_in[`SCG_CFG_ODIV_HI:`SCG_CFG_ODIV_LO];
            usb_pll_in_divider_q <=
                wdata_in[`SCG_CFG_UDIV_HI:`SCG_CFG_UDIV_LO];
        end
        if (latch_wr) begin
            latched_q <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Frequency arithmetic and checks

// Zero dividers are treated as one so the arithmetic stays defined
wire [3:0] idiv = (sys_pll_in_divider_q == 4'h0) ? 4'h1 :
    sys_pll_in_divider_q;
wire [7:0] odiv = (sys_pll_out_divider_q == 8'h00) ? 8'h01 :
    sys_pll_out_divider_q;
wire [3:0] udiv = (usb_pll_in_divider_q == 4'h0) ? 4'h1 :
    usb_pll_in_divider_q;
wire [31:0] pll_in_hz = `SCG_PRI_IN_HZ / {28'h0000000, idiv};
wire [39:0] vco_hz = pll_in_hz * {32'h00000000, sys_pll_multiplier_q};
wire [39:0] core_calc_hz = vco_hz / {32'h00000000, odiv};
wire too_fast = (sys_pll_multiplier_q == 8'h00) ||
    (core_calc_hz > {8'h00, MAX_HZ});
wire usb_bad = usb_pll_on_q &&
    ((`SCG_PRI_IN_HZ / {28'h0000000, udiv}) != `SCG_USB_IN_HZ);

always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        lock_cnt_q <= 32'h00000000;
        locked_q <= 1'b0;
        core_hz_q <= 32'h00000000;
        cfg_error_out <= 1'b0;
        usb_cfg_error_out <= 1'b0;
    end else begin
        cfg_error_out <= too_fast;
        usb_cfg_error_out <= usb_bad;
        if (latched_q && !locked_q && !too_fast) begin
            if (lock_cnt_q == `SCG_LOCK_CYC - 32'd1) begin
                locked_q <= 1'b1;
                core_hz_q <= core_calc_hz[31:0];
            end else begin
                lock_cnt_q <= lock_cnt_q + 32'd1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Primary select and rate enables

reg [31:0] core_acc_q;
reg [31:0] usb_acc_q;
reg [2:0] pb_cnt_q;

wire [32:0] core_sum = {1'b0, core_acc_q} + {1'b0, core_hz_q};
wire core_tick = locked_q && (core_sum >= {1'b0, MAX_HZ});
wire [32:0] usb_sum = {1'b0, usb_acc_q} + 33'h000000001;

reg [2:0] pb_mask;
wire pb_wrap = ((pb_cnt_q & pb_mask) == pb_mask);
wire primary_sel = (primary_osc_mode_sel_q == `SCG_MODE_CRYSTAL);

always @* begin
    case (periph_bus_divider_q)
        `SCG_PB_DIV1: begin
            pb_mask = 3'h0;
        end
        `SCG_PB_DIV2: begin
            pb_mask = 3'h1;
        end
        `SCG_PB_DIV4: begin
            pb_mask = 3'h3;
        end
        default: begin
            pb_mask = 3'h7;
        end
    endcase
end

// Only the selected source reaches the primary output
always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        primary_clk_out <= 1'b0;
    end else if (primary_sel) begin
        primary_clk_out <= crystal_in;
    end else begin
        primary_clk_out <= ext_clk_in;
    end
end

// Core enable is a phase accumulator against the fastest legal rate
always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        core_acc_q <= 32'h00000000;
        core_clock_out <= 1'b0;
    end else begin
        if (core_tick) begin
            core_acc_q <= core_sum[31:0] - MAX_HZ;
        end else begin
            core_acc_q <= core_sum[31:0];
        end
        core_clock_out <= core_tick;
    end
end

// Bus tick rides on a core tick, so both domains stay edge aligned
always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        pb_cnt_q <= 3'h0;
        peripheral_bus_clock_out <= 1'b0;
    end else if (core_tick) begin
        if (pb_wrap) begin
            pb_cnt_q <= 3'h0;
        end else begin
            pb_cnt_q <= pb_cnt_q + 3'h1;
        end
        peripheral_bus_clock_out <= pb_wrap;
    end else begin
        peripheral_bus_clock_out <= 1'b0;
    end
end

// USB enable: nominal 48 MHz, 12 ticks per 25 cycles
wire usb_run = usb_pll_on_q && locked_q && !usb_bad;
wire usb_wrap = (usb_sum[31:0] >= 32'd25);
wire usb_slot = !usb_acc_q[0] && (usb_acc_q < 32'd24);

always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        usb_acc_q <= 32'h00000000;
        usb_pll_clock_out <= 1'b0;
    end else if (usb_run) begin
        if (usb_wrap) begin
            usb_acc_q <= 32'h00000000;
        end else begin
            usb_acc_q <= usb_sum[31:0];
        end
        usb_pll_clock_out <= usb_slot;
    end else begin
        usb_pll_clock_out <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Register read port

reg [31:0] rdata_d;

wire [31:0] cfg_word = {
    4'h0,
    usb_pll_in_divider_q,
    sys_pll_out_divider_q,
    sys_pll_multiplier_q,
    sys_pll_in_divider_q,
    usb_pll_on_q,
    periph_bus_divider_q,
    primary_osc_mode_sel_q
};

wire [31:0] stat_word = {
    27'h0000000,
    usb_bad,
    too_fast,
    locked_q,
    latched_q,
    usb_pll_on_q
};

// Zero outside the read slot so stale words never look like data
always @* begin
    rdata_d = 32'h00000000;
    if (rd_in) begin
        case (addr_in)
            `SCG_REG_CFG: begin
                rdata_d = cfg_word;
            end
            `SCG_REG_STAT: begin
                rdata_d = stat_word;
            end
            `SCG_REG_FREQ: begin
                rdata_d = core_calc_hz[31:0];
            end
            `SCG_REG_LATCH: begin
                rdata_d = {31'h00000000, latched_q};
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end
end

always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        rdata_out <= 32'h00000000;
    end else begin
        rdata_out <= rdata_d;
    end
end

endmodule

// ==== hdl/scg_defs.vh ====
`ifndef SCG_DEFS_VH
`define SCG_DEFS_VH

// Primary input and limits, in Hz
`define SCG_PRI_IN_HZ 32'd8000000
`define SCG_CORE_MAX_HZ 32'd80000000
`define SCG_USB_IN_HZ 32'd4000000

// Oscillator mode encodings
`define SCG_MODE_EXT_CLK 1'b0
`define SCG_MODE_CRYSTAL 1'b1

// Peripheral bus divider encodings: 1, 2, 4, 8
`define SCG_PB_DIV1 2'h0
`define SCG_PB_DIV2 2'h1
`define SCG_PB_DIV4 2'h2
`define SCG_PB_DIV8 2'h3

// Register offsets
`define SCG_REG_CFG 4'h0
`define SCG_REG_STAT 4'h1
`define SCG_REG_FREQ 4'h2
`define SCG_REG_LATCH 4'h3

// CFG field positions
`define SCG_CFG_MODE 0
`define SCG_CFG_PBDIV_LO 1
`define SCG_CFG_PBDIV_HI 2
`define SCG_CFG_USBON 3
`define SCG_CFG_IDIV_LO 4
`define SCG_CFG_IDIV_HI 7
`define SCG_CFG_MUL_LO 8
`define SCG_CFG_MUL_HI 15
`define SCG_CFG_ODIV_LO 16
`define SCG_CFG_ODIV_HI 23
`define SCG_CFG_UDIV_LO 24
`define SCG_CFG_UDIV_HI 27

// Reset values: /2, x20, /1, pb /8, usb off, usb in /2
`define SCG_RST_IDIV 4'h2
`define SCG_RST_MUL 8'h14
`define SCG_RST_ODIV 8'h01
`define SCG_RST_UDIV 4'h2

// Lock settle time after latch
`define SCG_LOCK_NS 32'd1000
`define SCG_CLK_NS 32'd10
`define SCG_LOCK_CYC ((`SCG_LOCK_NS + `SCG_CLK_NS - 32'd1) / `SCG_CLK_NS)

`endif

// ==== verification/scg_chk.sv ====
`timescale 1ns/100ps
module scg_chk (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire core_clock_out,
    input wire peripheral_bus_clock_out,
    input wire usb_pll_clock_out,
    input wire cfg_error_out,
    input wire usb_cfg_error_out
);
////////////////////////////////////////////////////////////////////////////
// Cycles since the first latch; later latch writes must not restart it
reg [7:0] since_q;
always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in)
        since_q <= 8'h00;
    else if (since_q != 8'h00 && since_q != 8'hff)
        since_q <= since_q + 8'h01;
    else if (since_q == 8'h00 && wr_in && addr_in == 4'h3 && wdata_in[0])
        since_q <= 8'h01;
end
default clocking cb @(posedge sys_clk_in); endclocking
default disable iff (!resetn_in);
a_read_idle: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read slot");
a_unmapped_zero: assert property (
    rd_in && addr_in > 4'h3 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
a_pb_on_core: assert property (
    peripheral_bus_clock_out |-> core_clock_out)
    else $error("bus tick without core tick");
a_fast_no_core: assert property (
    cfg_error_out |-> !core_clock_out)
    else $error("core ticks with bad setting");
a_usb_bad_quiet: assert property (
    usb_cfg_error_out |-> !usb_pll_clock_out)
    else $error("usb ticks with bad divider");
a_core_after_lock: assert property (
    core_clock_out |-> since_q >= 8'h64)
    else $error("core tick before lock");
a_usb_after_lock: assert property (
    usb_pll_clock_out |-> since_q >= 8'h64)
    else $error("usb tick before lock");
a_err_frozen: assert property (
    since_q >= 8'h04 |-> $stable({cfg_error_out, usb_cfg_error_out}))
    else $error("error flags moved after latch");
endmodule
bind scg_system_clock_generator scg_chk u_scg_chk (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .core_clock_out(core_clock_out),
    .peripheral_bus_clock_out(peripheral_bus_clock_out),
    .usb_pll_clock_out(usb_pll_clock_out), .cfg_error_out(cfg_error_out),
    .usb_cfg_error_out(usb_cfg_error_out));

// ==== verification/scg_osc_model.sv ====
`timescale 1ns/100ps
module scg_osc_model (
    output reg ext_clk_out,
    output reg crystal_out
);
// 8 MHz sources, offset so no edge meets a 100 MHz rising edge
initial begin
    ext_clk_out = 1'b0;
    #1 forever #62.5 ext_clk_out = ~ext_clk_out;
end
initial begin
    crystal_out = 1'b0;
    #33 forever #62.5 crystal_out = ~crystal_out;
end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/100ps
module tb;
reg sys_clk_in = 1'b0;
reg resetn_in = 1'b0;
reg [3:0] addr_in = 4'h0;
reg [31:0] wdata_in = 32'h0;
reg wr_in = 1'b0;
reg rd_in = 1'b0;
wire [31:0] rdata_out;
wire ext_clk, crystal, prim, core, pbc, usbc, cerr, uerr;
integer miscompares = 0;
integer samples_checked = 0;
integer k;
reg [31:0] rv;
initial forever #5 sys_clk_in = ~sys_clk_in;
scg_osc_model osc (.ext_clk_out(ext_clk), .crystal_out(crystal));
scg_system_clock_generator DUT (.sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in), .ext_clk_in(ext_clk), .crystal_in(crystal),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .primary_clk_out(prim), .core_clock_out(core),
    .peripheral_bus_clock_out(pbc), .usb_pll_clock_out(usbc),
    .cfg_error_out(cerr), .usb_cfg_error_out(uerr));
////////////////////////////////////////////////////////////////////////////
task print_verdict;
    if (miscompares == 0 && samples_checked > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
task chk(input string nm, input [31:0] exp, input [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0s exp %h got %h", nm, exp, got);
    end
endtask
task near(input string nm, input integer exp, input integer got,
    input integer tol);
    samples_checked = samples_checked + 1;
    if (got > exp + tol || got < exp - tol) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0s exp %0d got %0d", nm, exp, got);
    end
endtask
task wr(input [3:0] a, input [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
endtask
task rd(input [3:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
endtask
task do_reset;
    resetn_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
endtask
////////////////////////////////////////////////////////////////////////////
task t_defaults;
    rd(4'h0); chk("cfg", 32'h02011426, rv);
    rd(4'h1); chk("stat", 32'h0, rv);
    rd(4'h2); chk("freq", 32'h04c4b400, rv);
    rd(4'hc); chk("unmapped", 32'h0, rv);
    chk("cfgerr", 32'h0, {31'h0, cerr});
endtask
// Multiplier 24 gives 96 MHz: flagged, never locks
task t_too_fast;
    wr(4'h0, 32'h02011826);
    rd(4'h2); chk("freq", 32'h05b8d800, rv);
    chk("cfgerr", 32'h1, {31'h0, cerr});
    wr(4'h3, 32'h1);
    repeat (150) @(posedge sys_clk_in);
    rd(4'h1); chk("stat", 32'h0a, rv);
endtask
// 60 MHz core; code picks mode, bus divider and usb setting
task t_run(input [1:0] c);
    integer i, nc, np, nu, bad;
    reg [31:0] w;
    w = {4'h0, (c == 2'd2) ? 4'h1 : 4'h2, 16'h010f, 4'h2, c[1], c, c[0]};
    nc = 0; np = 0; nu = 0; bad = 0;
    do_reset;
    wr(4'h0, w);
    wr(4'h3, 32'h1);
    wr(4'h0, 32'h0);
    rd(4'h0); chk("cfg", w, rv);
    chk("usberr", {31'h0, c == 2'd2}, {31'h0, uerr});
    repeat (110) @(posedge sys_clk_in);
    for (i = 0; i < 400; i = i + 1) begin
        @(posedge sys_clk_in);
        w[0] = c[0] ? crystal : ext_clk;
        #1;
        if (prim !== w[0]) bad = bad + 1;
        if (core === 1'b1) nc = nc + 1;
        if (pbc === 1'b1) np = np + 1;
        if (usbc === 1'b1) nu = nu + 1;
    end
    near("prim", 0, bad, 0);
    near("core", 300, nc, 1);
    near("pbus", 300 >> c, np, 1);
    near("usb", (c == 2'd3) ? 192 : 0, nu, 2);
    rd(4'h2); chk("freq", 32'h03938700, rv);
    rd(4'h1); chk("stat", {27'h0, c == 2'd2, 3'h3, c[1]}, rv);
endtask
initial begin
    do_reset;
    t_defaults;
    t_too_fast;
    for (k = 0; k < 4; k = k + 1) t_run(k[1:0]);
    print_verdict;
end
initial begin
    #60000;
    miscompares = miscompares + 1;
    print_verdict;
end
endmodule
